/* File: inc/plt_pkg.sv */
// Constants and state layout for the period timer with optional limit reset.
// Assumes a single 100 MHz clock and a plain strobe register port.
package plt_pkg;

    // Clock rate and the instruction-clock divide (system clock over four).
    localparam int        CLK_MHZ      = 100;
    localparam logic [1:0] INSTR_LAST  = 2'h3;

    // Register indices on the address port.
    localparam logic [2:0] ADDR_COUNT  = 3'h0;
    localparam logic [2:0] ADDR_PERIOD = 3'h1;
    localparam logic [2:0] ADDR_CTRL0  = 3'h2;
    localparam logic [2:0] ADDR_CTRL1  = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;

    // Control register zero fields.
    localparam int CTRL0_POST_LSB = 3;
    localparam int CTRL0_RUN_BIT  = 2;
    localparam int CTRL0_PRE_LSB  = 0;

    // Control register one fields (limit form only).
    localparam int CTRL1_FES_BIT   = 7;
    localparam int CTRL1_RES_BIT   = 6;
    localparam int CTRL1_ERS_LSB   = 2;
    localparam int CTRL1_FEREN_BIT = 1;
    localparam int CTRL1_REREN_BIT = 0;

    // Status register fields.
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_IE_BIT   = 1;

    // Reset values of count and period.
    localparam logic [7:0] COUNT_RST  = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hff;

    // Last prescaler count for each prescale code: 1, 4, 16, 64.
    localparam logic [5:0] PRE_LAST_1  = 6'h00;
    localparam logic [5:0] PRE_LAST_4  = 6'h03;
    localparam logic [5:0] PRE_LAST_16 = 6'h0f;
    localparam logic [5:0] PRE_LAST_64 = 6'h3f;

    // Complete state of one timer.
    typedef struct packed {
        logic [1:0] quarter;
        logic [5:0] pre;
        logic [3:0] post;
        logic [7:0] cnt;
        logic [7:0] per;
        logic       run;
        logic [1:0] psel;
        logic [3:0] osel;
        logic [2:0] ers;
        logic       fes;
        logic       res;
        logic       feren;
        logic       reren;
        logic       sync1;
        logic       sync2;
        logic       sync3;
        logic       filt;
        logic       pend;
        logic       flag;
        logic       ie;
        logic       match;
        logic       irq;
        logic [7:0] rdata;
    } plt_state_t;

    localparam plt_state_t STATE_RST = '{
        quarter: 2'h0, pre: 6'h00, post: 4'h0, cnt: COUNT_RST, per: PERIOD_RST,
        run: 1'b0, psel: 2'h0, osel: 4'h0, ers: 3'h0, fes: 1'b0, res: 1'b0,
        feren: 1'b0, reren: 1'b0, sync1: 1'b0, sync2: 1'b0, sync3: 1'b0,
        filt: 1'b0, pend: 1'b0, flag: 1'b0, ie: 1'b0, match: 1'b0, irq: 1'b0,
        rdata: 8'h00};

endpackage

/* File: logic/plt_timer.sv */
// Eight-bit period timer with prescaler, postscaler and optional limit reset.
// Assumes one clock, a synchronous reset that stands for every device reset,
// and peripheral outputs on srcIn that are asynchronous to clk.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module plt_timer
    import plt_pkg::*;
#(
    parameter bit LIMIT_EN = 1'b1
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       srst,
    // Register port.
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStb,
    input  wire logic       rdStb,
    output logic      [7:0] rdData,
    // Peripheral reset sources, in select-code order.
    input  wire logic [5:0] srcIn,
    // Timer outputs.
    output logic            limitMatch,
    output logic            matchFlag,
    output logic            intReq
);

    plt_state_t st;
    plt_state_t nx;

    // Decoded strobes and per-cycle events.
    logic       wrCount;
    logic       wrCtrl0;
    logic       instrEn;
    logic       tick;
    logic [5:0] preLast;
    logic       srcSel;
    logic       filtNext;
    logic       riseEv;
    logic       fallEv;
    logic       flagSet;

    assign wrCount = wrStb && (addr == ADDR_COUNT);
    assign wrCtrl0 = wrStb && (addr == ADDR_CTRL0);

    // Instruction clock enable: one pulse in four system clocks.
    assign instrEn = (st.quarter == INSTR_LAST);

    // Prescale code to last prescaler count.
    always_comb begin
        case (st.psel)
            2'h0:    preLast = PRE_LAST_1;
            2'h1:    preLast = PRE_LAST_4;
            2'h2:    preLast = PRE_LAST_16;
            default: preLast = PRE_LAST_64;
        endcase
    end

    // A scaler-clearing write blocks the advance in its own cycle.
    assign tick = instrEn && st.run && (st.pre == preLast) && !wrCount && !wrCtrl0;

    // Postscaler output this cycle; it outranks a software clear of the flag.
    assign flagSet = tick && !(LIMIT_EN && st.pend)
                     && (st.cnt == st.per) && (st.post == st.osel);

    // Switching the source can look like one edge, which arms one early clear.
    // Source selection; reserved codes give a constant zero.
    always_comb begin
        case (st.ers)
            3'h0:    srcSel = srcIn[0];
            3'h1:    srcSel = srcIn[1];
            3'h2:    srcSel = srcIn[2];
            3'h3:    srcSel = srcIn[3];
            3'h4:    srcSel = srcIn[4];
            3'h5:    srcSel = srcIn[5];
            default: srcSel = 1'b0;
        endcase
    end

    // Filtered level changes only once the last two sync stages agree.
    assign filtNext = (st.sync2 == st.sync3) ? st.sync2 : st.filt;

    // Edge mode catches transitions, level mode catches the held level.
    assign riseEv = st.reren && (st.res ? (filtNext && !st.filt) : filtNext);
    assign fallEv = st.feren && (st.fes ? (!filtNext && st.filt) : !filtNext);

    // Next-state logic for the whole timer.
    always_comb begin
        nx = st;
        // The quarter phase runs free; writes never shift the instruction clock.
        nx.quarter = 2'(st.quarter + 2'h1);

        // Prescaler runs on the instruction clock while the timer is on.
        if (instrEn && st.run) begin
            nx.pre = (st.pre == preLast) ? 6'h00 : 6'(st.pre + 6'h01);
        end

        // Count advance, early restart, or match wrap.
        if (tick) begin
            if (LIMIT_EN && st.pend) begin
                nx.cnt  = COUNT_RST;
                nx.pend = 1'b0;
            end else if (st.cnt == st.per) begin
                nx.cnt = COUNT_RST;
                if (st.post == st.osel) begin
                    nx.post = 4'h0;
                    nx.flag = 1'b1;
                end else begin
                    nx.post = 4'(st.post + 4'h1);
                end
            end else begin
                nx.cnt = 8'(st.cnt + 8'h01);
            end
        end

        // Limit-form event path: sync chain and pending clear.
        if (LIMIT_EN) begin
            nx.sync1 = srcSel;
            nx.sync2 = st.sync1;
            nx.sync3 = st.sync2;
            nx.filt  = filtNext;
            if (riseEv || fallEv) begin
                nx.pend = 1'b1;
            end
        end

        // Register writes; count write beats any event and drops it.
        if (wrStb) begin
            case (addr)
                ADDR_COUNT: begin
                    nx.cnt  = wrData;
                    nx.pre  = 6'h00;
                    nx.post = 4'h0;
                    nx.pend = 1'b0;
                end
                ADDR_PERIOD: begin
                    nx.per = wrData;
                end
                ADDR_CTRL0: begin
                    nx.osel = wrData[CTRL0_POST_LSB +: 4];
                    nx.run  = wrData[CTRL0_RUN_BIT];
                    nx.psel = wrData[CTRL0_PRE_LSB +: 2];
                    nx.pre  = 6'h00;
                    nx.post = 4'h0;
                end
                ADDR_CTRL1: begin
                    if (LIMIT_EN) begin
                        nx.fes   = wrData[CTRL1_FES_BIT];
                        nx.res   = wrData[CTRL1_RES_BIT];
                        nx.ers   = wrData[CTRL1_ERS_LSB +: 3];
                        nx.feren = wrData[CTRL1_FEREN_BIT];
                        nx.reren = wrData[CTRL1_REREN_BIT];
                    end
                end
                ADDR_STATUS: begin
                    // Writing zero clears the flag unless a postscaler output sets it now.
                    if (!wrData[STAT_FLAG_BIT] && !flagSet) begin
                        nx.flag = 1'b0;
                    end
                    nx.ie = wrData[STAT_IE_BIT];
                end
                default: begin
                end
            endcase
        end

        // Outputs registered from the next state.
        nx.match = (nx.cnt == nx.per);
        nx.irq   = nx.flag && nx.ie;

        // Read data stands in the cycle after the read strobe.
        nx.rdata = 8'h00;
        if (rdStb) begin
            case (addr)
                ADDR_COUNT:  nx.rdata = st.cnt;
                ADDR_PERIOD: nx.rdata = st.per;
                ADDR_CTRL0:  nx.rdata = {1'b0, st.osel, st.run, st.psel};
                ADDR_CTRL1:  nx.rdata = {st.fes, st.res, 1'b0, st.ers, st.feren, st.reren};
                ADDR_STATUS: nx.rdata = {6'h00, st.ie, st.flag};
                default:     nx.rdata = 8'h00;
            endcase
        end
    end

    // State register; reset stands for every kind of device reset.
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= STATE_RST;
        end else begin
            st <= nx;
        end
    end

    assign rdData     = st.rdata;
    assign limitMatch = st.match;
    assign matchFlag  = st.flag;
    assign intReq     = st.irq;

    // Checks on the timer behaviour, all but two off while reset is held.
    // The reset checks carry their own clock and never switch off,
    // so they see the values that reset leaves behind.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    chk_count_write: assert property (
        wrCount |=> (st.cnt == $past(wrData)))
        else $error("Count write not stored.");

    chk_ctrl_keep_count: assert property (
        (wrCtrl0 && !wrCount) |=> (st.cnt == $past(st.cnt)))
        else $error("Control write changed the count.");

    chk_scaler_clear: assert property (
        (wrCount || wrCtrl0) |=> (st.pre == 6'h00 && st.post == 4'h0))
        else $error("Scalers not cleared by write.");

    chk_match_wrap: assert property (
        (tick && !st.pend && st.cnt == st.per) |=> (st.cnt == 8'h00))
        else $error("Count did not wrap on match.");

    chk_count_step: assert property (
        (tick && !st.pend && st.cnt != st.per) |=> (st.cnt == 8'($past(st.cnt) + 8'h01)))
        else $error("Count did not advance by one.");

    chk_stopped_hold: assert property (
        (!st.run && !wrCount) |=> $stable(st.cnt))
        else $error("Stopped timer moved.");

    chk_prescale_last: assert property (
        tick |-> (st.pre == preLast && instrEn))
        else $error("Tick away from prescale end.");

    chk_flag_set: assert property (
        (tick && !st.pend && st.cnt == st.per && st.post == st.osel) |=> st.flag)
        else $error("Postscaler output missed the flag.");

    chk_reset_values: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> (st.cnt == 8'h00 && st.per == 8'hff && st.pre == 6'h00))
        else $error("Reset values wrong.");

    chk_event_restart: assert property (
        (LIMIT_EN && tick && st.pend) |=> (st.cnt == 8'h00 && $stable(st.post)))
        else $error("Pending event did not restart count.");

    chk_irq_gate: assert property (
        intReq == (matchFlag && st.ie))
        else $error("Request not gated by enable.");

    // A count write drops any pending clear.
    chk_write_drops_pend: assert property (
        wrCount |=> !st.pend)
        else $error("Count write left a pending clear.");

    // A filtered rise with rising edge mode armed sets a pending clear.
    chk_rise_arms_pend: assert property (
        (st.reren && st.res && st.sync2 && st.sync3 && !st.filt && !wrCount) |=> st.pend)
        else $error("Rising event missed.");

    // A filtered fall with falling edge mode armed sets a pending clear.
    chk_fall_arms_pend: assert property (
        (st.feren && st.fes && !st.sync2 && !st.sync3 && st.filt && !wrCount) |=> st.pend)
        else $error("Falling event missed.");

    // A held high level in level mode keeps the clear armed.
    chk_level_rearm: assert property (
        (st.reren && !st.res && st.sync2 && st.sync3 && !wrCount) |=> st.pend)
        else $error("Level event not re-armed.");

    // Reserved source codes feed a constant zero.
    chk_reserved_zero: assert property (
        (st.ers[2:1] == 2'b11) |-> !srcSel)
        else $error("Reserved source not zero.");

    // Read data is zero outside the cycle after a read strobe.
    chk_read_one_cycle: assert property (
        !rdStb |=> (rdData == 8'h00))
        else $error("Read data stood too long.");

    // The limit output follows the count-equals-period level.
    chk_limit_output: assert property (
        limitMatch == (st.cnt == st.per))
        else $error("Limit output does not follow match.");

    // A match short of the postscale end steps the postscaler by one.
    chk_post_step: assert property (
        (tick && !st.pend && st.cnt == st.per && st.post != st.osel)
        |=> (st.post == 4'($past(st.post) + 4'h1)))
        else $error("Postscaler did not step.");

    // Bit 7 of control zero always reads as zero.
    chk_ctrl_bit7: assert property (
        (rdStb && addr == ADDR_CTRL0) |=> !rdData[7])
        else $error("Control bit 7 read as one.");

    // Reset clears the postscaler and any pending clear.
    chk_scaler_reset: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> (st.post == 4'h0 && !st.pend))
        else $error("Reset left scaler state.");

    // A period write stores the written value.
    chk_period_write: assert property (
        (wrStb && addr == ADDR_PERIOD) |=> (st.per == $past(wrData)))
        else $error("Period write not stored.");

    // The instruction clock enable is one pulse in every four clocks.
    chk_instr_rate: assert property (
        instrEn |=> (!instrEn [*3] ##1 instrEn))
        else $error("Instruction enable rate wrong.");

    // Clearing the flag with no postscaler output this cycle takes effect.
    chk_status_clear: assert property (
        (wrStb && addr == ADDR_STATUS && !wrData[STAT_FLAG_BIT] && !tick) |=> !matchFlag)
        else $error("Flag clear ignored.");

    // Main scenarios that the bench is expected to reach.
    cov_match: cover property (tick && st.cnt == st.per);
    cov_flag: cover property (!st.flag ##1 st.flag);
    cov_restart: cover property (tick && st.pend);
    cov_post_wrap: cover property (flagSet && st.osel == 4'hf);
    cov_level_event: cover property (st.reren && !st.res && riseEv);

endmodule

/* File: bench/plt_src_model.sv */
// Model of the peripheral outputs that feed the limit reset selector.
// Assumes the bench picks one output and starts or stops its toggling.
`timescale 1ns/1ps

module plt_src_model (
    // Clock.
    input  wire logic       clk,
    // Control from the bench.
    input  wire logic [2:0] toggleSel,
    input  wire logic       toggleOn,
    // Peripheral outputs, bit i is select code i.
    output logic      [5:0] srcOut = 6'h00
);
    logic [4:0] tick = 5'h00;

    // Flips the chosen output every 32 clocks, so it makes rising and falling events.
    always @(posedge clk) begin
        tick <= tick + 5'h01;
        if (toggleOn && tick == 5'h1f) begin
            srcOut[toggleSel] <= ~srcOut[toggleSel];
        end
    end
endmodule

/* File: bench/tb_plt_timer.sv */
// Self-checking bench for the period timer in its limit form.
// Assumes the register map of the timer package and a toggling source model.
`timescale 1ns/1ps

module tb_plt_timer;
    import plt_pkg::*;

    logic       clk         = 1'b0;
    logic       srst        = 1'b1;
    logic [2:0] addr        = 3'h0;
    logic [7:0] wrData      = 8'h00;
    logic       wrStb       = 1'b0;
    logic       rdStb       = 1'b0;
    logic [7:0] rdData;
    logic [5:0] srcIn;
    logic       limitMatch;
    logic       matchFlag;
    logic       intReq;
    logic [2:0] toggleSel   = 3'h0;
    logic       toggleOn    = 1'b0;
    logic [7:0] ctrl1Tab[4] = '{8'h45, 8'h92, 8'h1a, 8'h0d};
    logic [2:0] selTab[4]   = '{3'h1, 3'h4, 3'h0, 3'h3};
    int         mismatches  = 0;
    int         checks_done = 0;
    int         n;
    int         c;

    // Timer under test and the peripheral outputs it watches.
    plt_timer #(.LIMIT_EN(1'b1)) i_plt_timer (
        .clk(clk), .srst(srst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .srcIn(srcIn), .limitMatch(limitMatch),
        .matchFlag(matchFlag), .intReq(intReq));
    plt_src_model i_plt_src_model (
        .clk(clk), .toggleSel(toggleSel), .toggleOn(toggleOn), .srcOut(srcIn));

    // 100 MHz clock.
    always #5 clk = ~clk;

    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compares one value and reports a difference.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb  <= 1'b0;
    endtask

    // One-cycle register read; data is looked at in the following cycle.
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1;
        check(what, 16'(rdData), 16'(exp));
    endtask

    // Counts cycles up to the next rise of the limit output, under a bound.
    task automatic waitMatch(output int cyc);
        logic prev;
        prev = limitMatch;
        cyc  = 0;
        while (!(limitMatch === 1'b1 && prev === 1'b0)) begin
            prev = limitMatch;
            @(posedge clk);
            #1;
            cyc++;
            if (cyc > 5000) begin
                mismatches++;
                report_and_stop();
            end
        end
    endtask

    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(ADDR_COUNT, COUNT_RST, "count rst");
        rd(ADDR_PERIOD, PERIOD_RST, "period rst");
        rd(ADDR_STATUS, 8'h00, "status rst");
        wr(ADDR_CTRL0, 8'hff);
        rd(ADDR_CTRL0, 8'h7f, "ctrl0");
        wr(ADDR_CTRL1, 8'hff);
        rd(ADDR_CTRL1, 8'hdf, "ctrl1");
        wr(ADDR_CTRL1, 8'h00);
        wr(ADDR_CTRL0, 8'h00);
        wr(ADDR_COUNT, 8'h40);
        wr(ADDR_CTRL0, 8'h78);
        rd(ADDR_COUNT, 8'h40, "count kept");
        wr(ADDR_PERIOD, 8'h5a);
        rd(ADDR_PERIOD, 8'h5a, "period rw");
        rd(3'h5, 8'h00, "unmapped");
        // Match spacing is 4 x (period + 1) x prescale for every code.
        wr(ADDR_PERIOD, 8'h03);
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_CTRL0, 8'h04 | 8'(p));
            waitMatch(n);
            waitMatch(n);
            check("spacing", 16'(n), 16'(16 << (2 * p)));
        end
        // Matches per flag at both postscale ends; the enable gates the request.
        for (int k = 0; k < 16; k += 15) begin
            wr(ADDR_CTRL0, 8'(k << 3));
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_STATUS, (k != 0) ? 8'h02 : 8'h00);
            wr(ADDR_CTRL0, 8'h04 | 8'(k << 3));
            n = 0;
            while (matchFlag !== 1'b1 && n < 20) begin
                waitMatch(c);
                repeat (8) @(posedge clk);
                #1;
                n++;
            end
            check("post", 16'(n), 16'(k + 1));
            check("irq", 16'(intReq), 16'(k != 0));
        end
        // Source events hold the count below the period; in the two edge modes silence lets it match.
        wr(ADDR_PERIOD, 8'h20);
        for (int e = 0; e < 4; e++) begin
            wr(ADDR_CTRL0, 8'h00);
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CTRL1, ctrl1Tab[e]);
            toggleSel <= selTab[e];
            toggleOn  <= 1'b1;
            wr(ADDR_CTRL0, 8'h04);
            n = 0;
            repeat (600) begin
                @(posedge clk);
                #1;
                n += int'(limitMatch === 1'b1);
            end
            check("held", 16'(n), 16'h0000);
            @(posedge clk);
            toggleOn <= 1'b0;
            if (e < 2) begin
                waitMatch(n);
                rd(ADDR_COUNT, 8'h20, "count at match");
            end
        end
        // Reset in mid-run must restore count, period, control and status.
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(ADDR_COUNT, COUNT_RST, "count mid rst");
        rd(ADDR_PERIOD, PERIOD_RST, "period mid rst");
        rd(ADDR_CTRL0, 8'h00, "ctrl0 mid rst");
        rd(ADDR_STATUS, 8'h00, "status mid rst");
        report_and_stop();
    end
endmodule
